/* File: core/sinc3_decimation_filter.sv */
// sinc3 decimation filter: integrators, combs, settling control, normaliser
`timescale 1ns/10ps
`default_nettype none

module sinc3_decimation_filter #(
   parameter int DEC_WIDTH  = sinc3_pkg::DEC_WIDTH,
   parameter int MIN_DEC    = sinc3_pkg::MIN_DEC,
   parameter int OUT_WIDTH  = sinc3_pkg::OUT_WIDTH,
   parameter int FIFO_DEPTH = sinc3_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 nrst,
   // modulator stream
   input  wire logic                 mod_bit,
   // decimation word, high and low parts
   input  wire logic [3:0]           decimation_word_high,
   input  wire logic [7:0]           decimation_word_low,
   // restart sources
   input  wire logic                 restart_pin_n,
   input  wire logic                 filter_restart_bit,
   input  wire logic                 channel_change,
   // conversion words to the output data register
   output logic                      data_valid,
   input  wire logic                 data_ready,
   output logic      [OUT_WIDTH-1:0] data,
   // status and strobes
   output logic                      settling,
   output logic                      overrun,
   output logic                      mod_sample_tick,
   output logic                      ref_sample_tick
);

   localparam int AW = 3 * DEC_WIDTH + 2;
   localparam int QW = AW + sinc3_pkg::SCALE_SHIFT;
   localparam int SW = $clog2(QW + 1);

   // ----------------------------------------------------------------
   // parameter check
   // ----------------------------------------------------------------
   if (DEC_WIDTH != sinc3_pkg::HIGH_WIDTH + sinc3_pkg::LOW_WIDTH ||
       MIN_DEC < 2 || MIN_DEC >= (1 << DEC_WIDTH) ||
       OUT_WIDTH < sinc3_pkg::SCALE_SHIFT + 2) begin : g_bad_cfg
      $error("filter parameters out of range");
   end

   // ----------------------------------------------------------------
   // timebase
   // ----------------------------------------------------------------
   logic mod_tick;

   // reference strobe at clock over 64
   sinc3_timebase #(
      .MOD_DIV (sinc3_pkg::MOD_DIV),
      .REF_DIV (sinc3_pkg::REF_DIV)
   ) u_timebase (
      .clk      (clk),
      .nrst     (nrst),
      .mod_tick (mod_tick),
      .ref_tick (ref_sample_tick)
   );

   assign mod_sample_tick = mod_tick;

   // ----------------------------------------------------------------
   // restart pin synchroniser
   // ----------------------------------------------------------------
   logic [2:0] pin_sync;
   logic       pin_level;
   logic       next_pin_level;

   always_comb begin
      next_pin_level = (pin_sync[1] == pin_sync[2]) ? pin_sync[2] : pin_level;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_sync  <= 3'h7;
         pin_level <= 1'b1;
      end else begin
         pin_sync  <= {pin_sync[1:0], restart_pin_n};
         pin_level <= next_pin_level;
      end
   end

   // ----------------------------------------------------------------
   // decimation word and restart decision
   // ----------------------------------------------------------------
   function automatic logic [DEC_WIDTH-1:0] clamp_word(input logic [DEC_WIDTH-1:0] w);
      clamp_word = (w < DEC_WIDTH'(MIN_DEC)) ? DEC_WIDTH'(MIN_DEC) : w;
   endfunction

   logic [DEC_WIDTH-1:0] word_in;
   logic [DEC_WIDTH-1:0] dec_n;
   logic [AW-1:0]        dec_cube;
   logic                 hold;

   always_comb begin
      word_in = clamp_word({decimation_word_high, decimation_word_low});
      // pin, bit, channel change or new decimation word holds filter in restart
      hold    = !pin_level || filter_restart_bit || channel_change || (word_in != dec_n);
   end

   // ----------------------------------------------------------------
   // integrators and combs
   // ----------------------------------------------------------------
   logic [AW-1:0]        integ [3];
   logic [AW-1:0]        delay [3];
   logic [AW-1:0]        comb_out;
   logic [DEC_WIDTH-1:0] sample_cnt;
   logic [1:0]           settle_cnt;
   logic                 emit;
   logic [AW-1:0]        next_integ [3];
   logic [AW-1:0]        next_delay [3];
   logic [AW-1:0]        next_comb_out;
   logic [DEC_WIDTH-1:0] next_sample_cnt;
   logic [1:0]           next_settle_cnt;
   logic [DEC_WIDTH-1:0] next_dec_n;
   logic [AW-1:0]        next_dec_cube;
   logic                 next_emit;

   always_comb begin
      logic [AW-1:0] x;
      logic [AW-1:0] stage;
      logic          decim;
      x     = '0;
      stage = '0;
      decim = mod_tick && (sample_cnt == dec_n - 1'b1);
      next_integ      = integ;
      next_delay      = delay;
      next_comb_out   = comb_out;
      next_sample_cnt = sample_cnt;
      next_settle_cnt = settle_cnt;
      next_dec_n      = dec_n;
      next_dec_cube   = dec_cube;
      next_emit       = 1'b0;
      if (hold) begin
         // clearing integrators, delays and counters makes the third output fully settled
         next_integ      = '{default: '0};
         next_delay      = '{default: '0};
         next_sample_cnt = '0;
         next_settle_cnt = '0;
         next_dec_n      = word_in;
         next_dec_cube   = AW'(word_in) * AW'(word_in) * AW'(word_in);
      end else if (mod_tick) begin
         // bit mapped to plus or minus one
         x = mod_bit ? AW'(1) : {AW{1'b1}};
         // integrators wrap, combs undo the wrap
         next_integ[0] = integ[0] + x;
         next_integ[1] = integ[1] + next_integ[0];
         next_integ[2] = integ[2] + next_integ[1];
         next_sample_cnt = decim ? '0 : sample_cnt + 1'b1;
         if (decim) begin
            // unit-delay combs at the decimated rate
            // response fixed by the sinc3 structure
            stage = next_integ[2];
            for (int k = 0; k < 3; k++) begin
               next_delay[k] = stage;
               stage         = stage - delay[k];
            end
            next_comb_out = stage;
            // third output after restart is the first one passed on
            next_emit = (settle_cnt >= 2'(sinc3_pkg::SETTLE_PERIODS - 1));
            if (settle_cnt != 2'(sinc3_pkg::SETTLE_PERIODS)) begin
               next_settle_cnt = settle_cnt + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         integ      <= '{default: '0};
         delay      <= '{default: '0};
         comb_out   <= '0;
         sample_cnt <= '0;
         settle_cnt <= '0;
         dec_n      <= DEC_WIDTH'(MIN_DEC);
         dec_cube   <= AW'(MIN_DEC) * AW'(MIN_DEC) * AW'(MIN_DEC);
         emit       <= 1'b0;
      end else begin
         integ      <= next_integ;
         delay      <= next_delay;
         comb_out   <= next_comb_out;
         sample_cnt <= next_sample_cnt;
         settle_cnt <= next_settle_cnt;
         dec_n      <= next_dec_n;
         dec_cube   <= next_dec_cube;
         emit       <= next_emit;
      end
   end

   assign settling = (settle_cnt != 2'(sinc3_pkg::SETTLE_PERIODS));

   // ----------------------------------------------------------------
   // normaliser: divides by N cubed, one quotient bit per clock
   // ----------------------------------------------------------------
   sinc3_pkg::div_state_type div_state;
   sinc3_pkg::div_state_type next_div_state;
   logic [QW-1:0]            dividend;
   logic [QW-1:0]            quot;
   logic [AW-1:0]            rem;
   logic [SW-1:0]            step;
   logic                     negative;
   logic [OUT_WIDTH-1:0]     result;
   logic                     fifo_ready;
   logic [QW-1:0]            next_dividend;
   logic [QW-1:0]            next_quot;
   logic [AW-1:0]            next_rem;
   logic [SW-1:0]            next_step;
   logic                     next_negative;
   logic [OUT_WIDTH-1:0]     next_result;
   logic                     next_overrun;

   always_comb begin
      logic [AW-1:0]        trial;
      logic [AW-1:0]        mag;
      logic [OUT_WIDTH-1:0] q;
      trial          = {rem[AW-2:0], dividend[QW-1]};
      mag            = comb_out[AW-1] ? -comb_out : comb_out;
      q              = quot[OUT_WIDTH-1:0];
      next_div_state = div_state;
      next_dividend  = dividend;
      next_quot      = quot;
      next_rem       = rem;
      next_step      = step;
      next_negative  = negative;
      next_result    = result;
      // a new word while the last is still pending is lost and flagged
      next_overrun   = (overrun && !hold) || (emit && div_state != sinc3_pkg::DIV_IDLE);
      unique case (div_state)
         sinc3_pkg::DIV_IDLE: begin
            if (emit) begin
               // full scale maps to 2^22, leaving a factor two of headroom
               next_dividend  = {mag, {sinc3_pkg::SCALE_SHIFT{1'b0}}};
               next_negative  = comb_out[AW-1];
               next_rem       = '0;
               next_quot      = '0;
               next_step      = '0;
               next_div_state = sinc3_pkg::DIV_RUN;
            end
         end
         sinc3_pkg::DIV_RUN: begin
            // restoring division by N cubed in one pass, one quotient bit per step
            next_dividend = {dividend[QW-2:0], 1'b0};
            if (trial >= dec_cube) begin
               next_rem  = trial - dec_cube;
               next_quot = {quot[QW-2:0], 1'b1};
            end else begin
               next_rem  = trial;
               next_quot = {quot[QW-2:0], 1'b0};
            end
            next_step = step + 1'b1;
            if (hold) begin
               next_div_state = sinc3_pkg::DIV_IDLE;
            end else if (step == SW'(QW)) begin
               next_result    = negative ? -q : q;
               next_dividend  = dividend;
               next_quot      = quot;
               next_rem       = rem;
               next_div_state = sinc3_pkg::DIV_PUSH;
            end
         end
         sinc3_pkg::DIV_PUSH: begin
            // full fifo stalls the normaliser here
            if (fifo_ready) begin
               next_div_state = sinc3_pkg::DIV_IDLE;
            end
         end
         default: begin
            next_div_state = sinc3_pkg::DIV_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_state <= sinc3_pkg::DIV_IDLE;
         dividend  <= '0;
         quot      <= '0;
         rem       <= '0;
         step      <= '0;
         negative  <= 1'b0;
         result    <= '0;
         overrun   <= 1'b0;
      end else begin
         div_state <= next_div_state;
         dividend  <= next_dividend;
         quot      <= next_quot;
         rem       <= next_rem;
         step      <= next_step;
         negative  <= next_negative;
         result    <= next_result;
         overrun   <= next_overrun;
      end
   end

   // ----------------------------------------------------------------
   // output buffer
   // ----------------------------------------------------------------
   sinc3_fifo #(
      .WIDTH (OUT_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .nrst      (nrst),
      .in_valid  (div_state == sinc3_pkg::DIV_PUSH),
      .in_ready  (fifo_ready),
      .in_data   (result),
      .out_valid (data_valid),
      .out_ready (data_ready),
      .out_data  (data)
   );

endmodule
`default_nettype wire

/* File: core/sinc3_fifo.sv */
// small valid/ready fifo held in flip-flops
`timescale 1ns/10ps
`default_nettype none
module sinc3_fifo #(
   parameter int WIDTH = sinc3_pkg::OUT_WIDTH,
   parameter int DEPTH = sinc3_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // ----------------------------------------------------------------
   // parameter check
   // ----------------------------------------------------------------
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_fifo
      $error("fifo depth must be a power of two, at least two");
   end

   // ----------------------------------------------------------------
   // storage and pointers
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      next_wr_ptr;
   logic [AW:0]      next_rd_ptr;
   logic             push;
   logic             pop;

   always_comb begin
      in_ready    = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
      out_valid   = wr_ptr != rd_ptr;
      push        = in_valid && in_ready;
      pop         = out_valid && out_ready;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      out_data    = mem[rd_ptr[AW-1:0]];
   end

   // no reset on storage: contents are only read behind out_valid
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

endmodule
`default_nettype wire

/* File: core/sinc3_pkg.sv */
// shared constants and types of the sinc3 decimation filter
package sinc3_pkg;

   // ----------------------------------------------------------------
   // decimation word
   // ----------------------------------------------------------------
   localparam int DEC_WIDTH      = 12;
   localparam int HIGH_WIDTH     = 4;
   localparam int LOW_WIDTH      = 8;
   localparam int MIN_DEC        = 19;

   // ----------------------------------------------------------------
   // timebase, master clock divisors
   // ----------------------------------------------------------------
   localparam int MOD_DIV        = 128;
   localparam int REF_DIV        = 64;

   // ----------------------------------------------------------------
   // datapath
   // ----------------------------------------------------------------
   localparam int SETTLE_PERIODS = 3;
   localparam int OUT_WIDTH      = 24;
   localparam int SCALE_SHIFT    = 22;
   localparam int FIFO_DEPTH     = 8;

   // ----------------------------------------------------------------
   // normalising divider
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      DIV_IDLE,
      DIV_RUN,
      DIV_PUSH
   } div_state_type;

endpackage

/* File: core/sinc3_timebase.sv */
// modulator and reference sample strobes derived from the master clock
`timescale 1ns/10ps
`default_nettype none
module sinc3_timebase #(
   parameter int MOD_DIV = sinc3_pkg::MOD_DIV,
   parameter int REF_DIV = sinc3_pkg::REF_DIV
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // strobes
   output logic      mod_tick,
   output logic      ref_tick
);

   localparam int CW = $clog2(MOD_DIV);

   // ----------------------------------------------------------------
   // parameter check
   // ----------------------------------------------------------------
   if (MOD_DIV < 2 || REF_DIV < 1 || (MOD_DIV % REF_DIV) != 0) begin : g_bad_div
      $error("timebase divisors must nest evenly");
   end

   // ----------------------------------------------------------------
   // divider
   // ----------------------------------------------------------------
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic          next_mod_tick;
   logic          next_ref_tick;

   always_comb begin
      next_count    = (count == CW'(MOD_DIV - 1)) ? '0 : count + 1'b1;
      next_mod_tick = (count == CW'(MOD_DIV - 1));
      next_ref_tick = ((count % CW'(REF_DIV)) == CW'(REF_DIV - 1));
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count    <= '0;
         mod_tick <= 1'b0;
         ref_tick <= 1'b0;
      end else begin
         count    <= next_count;
         mod_tick <= next_mod_tick;
         ref_tick <= next_ref_tick;
      end
   end

endmodule
`default_nettype wire

/* File: verification/sinc3_filter_sva.sv */
// port checker for the sinc3 decimation filter
`timescale 1ns/10ps
`default_nettype none
module sinc3_filter_checker #(
   parameter int MIN_DEC   = sinc3_pkg::MIN_DEC,
   parameter int OUT_WIDTH = sinc3_pkg::OUT_WIDTH
) (
   // clock and reset
   input wire logic                 clk,
   input wire logic                 nrst,
   // inputs
   input wire logic [3:0]           decimation_word_high,
   input wire logic [7:0]           decimation_word_low,
   input wire logic                 restart_pin_n,
   input wire logic                 filter_restart_bit,
   input wire logic                 channel_change,
   input wire logic                 data_ready,
   // outputs
   input wire logic                 data_valid,
   input wire logic [OUT_WIDTH-1:0] data,
   input wire logic                 settling,
   input wire logic                 overrun,
   input wire logic                 mod_sample_tick,
   input wire logic                 ref_sample_tick
);
   // earliest tick phase can shave one modulator period off the settle
   localparam int SETTLE_MIN = (3 * MIN_DEC - 1) * sinc3_pkg::MOD_DIV;
   // ------
   // helper counters
   // ------
   logic [7:0]  mod_gap, next_mod_gap, ref_gap, next_ref_gap;
   logic        mod_seen, next_mod_seen, ref_seen, next_ref_seen;
   logic [15:0] age, next_age;
   logic [11:0] prev_word;
   logic        restart_any;
   always_comb begin
      restart_any = channel_change | filter_restart_bit | !restart_pin_n
                  | (prev_word != {decimation_word_high, decimation_word_low});
      next_mod_gap = mod_sample_tick ? 8'h00 : mod_gap + 8'h01;
      next_ref_gap = ref_sample_tick ? 8'h00 : ref_gap + 8'h01;
      next_mod_seen = mod_seen | mod_sample_tick;
      next_ref_seen = ref_seen | ref_sample_tick;
      next_age = restart_any ? 16'h0000 : age + {15'h0000, age != 16'hFFFF};
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mod_gap   <= 8'h00;
         ref_gap   <= 8'h00;
         mod_seen  <= 1'b0;
         ref_seen  <= 1'b0;
         age       <= 16'h0000;
         prev_word <= 12'(MIN_DEC);
      end else begin
         mod_gap   <= next_mod_gap;
         ref_gap   <= next_ref_gap;
         mod_seen  <= next_mod_seen;
         ref_seen  <= next_ref_seen;
         age       <= next_age;
         prev_word <= {decimation_word_high, decimation_word_low};
      end
   end
   // ------
   // assertions
   // ------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   mod_tick_period_a: assert property (mod_sample_tick && mod_seen |-> mod_gap == 8'h7F)
      else $error("modulator tick spacing wrong");
   ref_tick_period_a: assert property (ref_sample_tick && ref_seen |-> ref_gap == 8'h3F)
      else $error("reference tick spacing wrong");
   data_hold_a: assert property (data_valid && !data_ready |=> data_valid && $stable(data))
      else $error("word changed before taken");
   settle_rise_a: assert property (channel_change |-> ##[1:3] settling)
      else $error("channel change did not restart");
   settle_time_a: assert property ($fell(settling) |-> 32'(age) >= SETTLE_MIN)
      else $error("settled in under three periods");
   restart_hold_a: assert property (filter_restart_bit [*3] |-> settling)
      else $error("restart bit not holding filter");
   first_word_a: assert property ($fell(settling) |-> ##[0:80] data_valid)
      else $error("no word after settling");
   overrun_keep_a: assert property (overrun && !restart_any && age > 16'h0008 |=> overrun)
      else $error("overrun cleared without restart");
   overrun_cause_a: assert property ($rose(overrun) |-> $past(data_valid) && !$past(data_ready))
      else $error("overrun without full stalled buffer");
   cover property ($fell(settling));
   cover property ($rose(overrun));
   cover property (data_valid && data_ready);
endmodule
bind sinc3_decimation_filter sinc3_filter_checker #(
   .MIN_DEC  (MIN_DEC),
   .OUT_WIDTH(OUT_WIDTH)
) chk (
   .clk, .nrst, .decimation_word_high, .decimation_word_low, .restart_pin_n,
   .filter_restart_bit, .channel_change, .data_ready, .data_valid, .data,
   .settling, .overrun, .mod_sample_tick, .ref_sample_tick
);
`default_nettype wire

/* File: verification/sinc3_partner.sv */
// modulator stream source and output register sink
`timescale 1ns/10ps
`default_nettype none
module sinc3_partner #(
   parameter int OUT_WIDTH = sinc3_pkg::OUT_WIDTH
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 nrst,
   // modulator side
   input  wire logic                 mod_sample_tick,
   input  wire logic                 level,
   output logic                      mod_bit,
   // output register side
   input  wire logic                 accept,
   input  wire logic                 data_valid,
   input  wire logic [OUT_WIDTH-1:0] data,
   output logic                      data_ready,
   output logic      [31:0]          word_cnt,
   output logic      [OUT_WIDTH-1:0] last_word
);
   // off-tick cycles carry the inverse so a mistimed sample shows
   // bit per tick
   initial mod_bit = 1'b0;
   always @(negedge clk)
      mod_bit <= mod_sample_tick ? level : ~level;
   assign data_ready = accept;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         word_cnt  <= 32'h0;
         last_word <= '0;
      end else if (data_valid && data_ready) begin
         word_cnt  <= word_cnt + 32'h1;
         last_word <= data;
      end
   end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the sinc3 decimation filter
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int P0 = sinc3_pkg::MIN_DEC * sinc3_pkg::MOD_DIV;
   localparam int N1 = 20;
   localparam int P1 = N1 * sinc3_pkg::MOD_DIV;
   // ------
   // signals
   // ------
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [3:0]  decimation_word_high = 4'h0;
   logic [7:0]  decimation_word_low = 8'h13;
   logic        restart_pin_n = 1'b1;
   logic        filter_restart_bit = 1'b0;
   logic        channel_change = 1'b0;
   logic        level = 1'b1;
   logic        accept = 1'b1;
   logic        mod_bit, data_valid, data_ready, settling, overrun;
   logic        mod_sample_tick, ref_sample_tick;
   logic [23:0] data, last_word;
   logic [31:0] word_cnt, word32;
   int          error_cnt = 0;
   int          n_compared = 0;
   int          cyc = 0;
   assign word32 = {8'h00, last_word};
   always #5 clk = ~clk;
   sinc3_decimation_filter dut (
      .clk, .nrst, .mod_bit, .decimation_word_high, .decimation_word_low,
      .restart_pin_n, .filter_restart_bit, .channel_change, .data_valid,
      .data_ready, .data, .settling, .overrun, .mod_sample_tick, .ref_sample_tick
   );
   sinc3_partner mdl (
      .clk, .nrst, .mod_sample_tick, .level, .mod_bit, .accept, .data_valid,
      .data, .data_ready, .word_cnt, .last_word
   );
   // ------
   // helpers
   // ------
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, msg, got, exp);
      end
   endtask
   task automatic flag(input logic f, input logic e, input string msg);
      cmp({31'h0, f}, {31'h0, e}, msg);
   endtask
   task automatic settle_chk(input int n, input int p, input string msg);
      n_compared++;
      if (n < 3 * p - sinc3_pkg::MOD_DIV || n > 3 * p + 200) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t %s after %0d cycles", $time, msg, n);
      end
   endtask
   function automatic logic [31:0] fs(input logic lv);
      logic signed [23:0] v;
      v = 24'sh1 <<< sinc3_pkg::SCALE_SHIFT;
      fs = {8'h00, lv ? v : -v};
   endfunction
   task automatic wait_word(output int n);
      logic [31:0] c0;
      c0 = word_cnt;
      n = 0;
      while (word_cnt === c0 && n < 40000) begin
         @(negedge clk);
         n++;
      end
   endtask
   // ------
   // scenarios
   // ------
   task automatic t_first;
      int n;
      wait_word(n);
      settle_chk(n, P0, "first word timing");
      cmp(word32, fs(1'b1), "positive full scale");
      flag(settling, 1'b0, "still settling");
      wait_word(n);
      cmp(n, P0, "output period");
      $display("test first_word done");
   endtask
   task automatic t_rate;
      int n;
      decimation_word_low = 8'(N1);
      level = 1'b0;
      wait_word(n);
      settle_chk(n, P1, "settle after word change");
      cmp(word32, fs(1'b0), "negative full scale");
      wait_word(n);
      cmp(n, P1, "period follows word");
      $display("test rate done");
   endtask
   task automatic t_fifo;
      int n;
      accept = 1'b0;
      repeat (10 * P1 + 200) @(negedge clk);
      flag(overrun, 1'b1, "lost word not flagged");
      flag(data_valid, 1'b1, "buffer not holding");
      n = word_cnt;
      accept = 1'b1;
      repeat (40) @(negedge clk);
      cmp(word_cnt - n, sinc3_pkg::FIFO_DEPTH + 1, "drained words");
      flag(data_valid, 1'b0, "buffer not empty");
      cmp(word32, fs(1'b0), "stored word");
      channel_change = 1'b1;
      @(negedge clk);
      channel_change = 1'b0;
      repeat (4) @(negedge clk);
      flag(overrun, 1'b0, "overrun not cleared");
      flag(settling, 1'b1, "output not held");
      wait_word(n);
      settle_chk(n, P1, "settle after channel change");
      $display("test fifo_channel done");
   endtask
   task automatic t_restart;
      int n;
      for (int s = 0; s < 2; s++) begin
         level = ~level;
         if (s == 0) filter_restart_bit = 1'b1;
         else restart_pin_n = 1'b0;
         repeat (5) @(negedge clk);
         flag(settling, 1'b1, "not held while restarting");
         filter_restart_bit = 1'b0;
         restart_pin_n = 1'b1;
         wait_word(n);
         settle_chk(n, P1, "settle after restart");
         cmp(word32, fs(level), "value after restart");
      end
      $display("test restart done");
   endtask
   task automatic t_step;
      int n;
      level = ~level;
      repeat (4) wait_word(n);
      flag(settling, 1'b0, "plain step restarted filter");
      cmp(word32, fs(level), "value four words after step");
      $display("test step done");
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t run too long", $time);
         conclude;
      end
   end
   initial begin
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      t_first;
      t_rate;
      t_fifo;
      t_restart;
      t_step;
      conclude;
   end
endmodule
`default_nettype wire
